//--- logic/fg_pkg.sv
/*
  Shared constants, types and helper functions for the flash/EEPROM
  access guard. Assumes the flash and EEPROM arrays are separate macros
  that answer a read strobe with data on the following cycle.
*/
package fg_pkg;

  // -------------------------------------------------------------------
  // geometry and address decode
  // -------------------------------------------------------------------
  localparam int FG_ROW_W = 13;
  localparam int FG_BLK_N = 256;
  localparam int FG_EE_ROW_W = 7;
  localparam int FG_EE_ADDR_W = 11;
  localparam logic [12:0] FG_EE_BASE_HI = 13'h0010;
  localparam logic [10:0] FG_ECC_BASE_HI = 11'h040;
  localparam logic [3:0] FG_CHK_SLOT = 4'h8;
  localparam logic [7:0] FG_REFUSED_DATA = 8'h00;
  localparam logic [71:0] FG_FL_LATCH_RST = 72'h00;
  localparam logic [127:0] FG_EE_LATCH_RST = 128'h00;

  // -------------------------------------------------------------------
  // enumerations
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    FG_PROT_OPEN = 2'b00,
    FG_PROT_FACTORY = 2'b01,
    FG_PROT_FIELD = 2'b10,
    FG_PROT_LOCKED = 2'b11
  } fg_prot_t;

  localparam fg_prot_t FG_PROT_RST = FG_PROT_OPEN;

  typedef enum logic [2:0] {
    FG_OP_FL_READ = 3'b000,
    FG_OP_FL_LOAD = 3'b001,
    FG_OP_FL_PROG = 3'b010,
    FG_OP_ERASE_ALL = 3'b011,
    FG_OP_SET_PROT = 3'b100,
    FG_OP_EE_LOAD = 3'b101,
    FG_OP_EE_WRITE = 3'b110
  } fg_op_t;

  typedef enum logic [1:0] {
    FG_SRC_FETCH = 2'b00,
    FG_SRC_CPU = 2'b01,
    FG_SRC_PGM = 2'b10
  } fg_src_t;

  typedef enum logic [1:0] {
    FG_S_IDLE = 2'b00,
    FG_S_ISSUE = 2'b01,
    FG_S_CAPT = 2'b10,
    FG_S_WAIT = 2'b11
  } fg_state_t;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    fg_op_t op;
    logic ext;
    logic [15:0] addr;
    logic [7:0] data;
  } fg_pgm_cmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic erase_all;
    logic [FG_ROW_W-1:0] row;
    logic [71:0] wdata;
  } fg_flash_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [FG_EE_ADDR_W-1:0] addr;
    logic [127:0] wdata;
  } fg_ee_req_t;

  // -------------------------------------------------------------------
  // functions
  // -------------------------------------------------------------------
  // codeword position of data bit idx: skips the power-of-two slots
  function automatic logic [6:0] fg_data_pos(input int idx);
    int p;
    int n;
    logic [6:0] r;
    r = 7'h00;
    n = 0;
    for (p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == idx) begin
          r = p[6:0];
        end
        n++;
      end
    end
    return r;
  endfunction

  // hamming bits low, overall parity on top so that ^{data,chk} == 0
  function automatic logic [7:0] fg_ecc_gen(input logic [63:0] d);
    logic [6:0] h;
    int i;
    h = 7'h00;
    for (i = 0; i < 64; i++) begin
      if (d[i]) begin
        h = h ^ fg_data_pos(i);
      end
    end
    return {(^d) ^ (^h), h};
  endfunction

  function automatic logic [7:0] fg_byte(input logic [63:0] d,
                                         input logic [2:0] i);
    return d[{i, 3'b000} +: 8];
  endfunction

  function automatic logic fg_allow(input fg_prot_t lvl, input logic ext,
                                    input logic wr);
    case (lvl)
      FG_PROT_OPEN: return 1'b1;
      FG_PROT_FACTORY: return !(ext && !wr);
      FG_PROT_FIELD: return !ext;
      FG_PROT_LOCKED: return !ext && !wr;
      default: return 1'b0;
    endcase
  endfunction

endpackage

//--- logic/fg_secded.sv
/*
  Single-error-correct, double-error-detect checker for one flash row
  of 8 data bytes and 1 check byte. Purely combinational; the caller
  registers whatever it keeps.
*/
module fg_secded
  import fg_pkg::*;
(
  input wire logic [63:0] data_i,
  input wire logic [7:0] chk_i,
  input wire logic en_i,
  output logic [63:0] data_o,
  output logic sbe_o,
  output logic dbe_o
);

  // -------------------------------------------------------------------
  // syndrome
  // -------------------------------------------------------------------
  wire logic [7:0] gen = fg_ecc_gen(data_i);
  wire logic [6:0] syn = gen[6:0] ^ chk_i[6:0];
  wire logic par = ^{data_i, chk_i};
  logic [63:0] flip;

  for (genvar i = 0; i < 64; i++) begin : g_flip
    assign flip[i] = (syn == fg_data_pos(i));
  end

  // -------------------------------------------------------------------
  // correction
  // -------------------------------------------------------------------
  // a syndrome that names a check bit leaves the data untouched
  assign sbe_o = en_i && par;
  assign dbe_o = en_i && !par && (syn != 7'h00);
  assign data_o = sbe_o ? (data_i ^ flip) : data_i;

endmodule

//--- logic/fg_guard.sv
/*
  Access guard in front of main flash, the check-byte/config flash area
  and the EEPROM. Serves instruction fetches through an 8-byte row
  buffer, direct data reads of EEPROM and the check-byte area, and a
  programming command port. Assumes both array macros answer a read
  strobe with data one cycle later and raise busy one cycle after a
  write strobe, holding it until the operation ends.
*/

module fg_guard
  import fg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ecc_en_i,
  input wire logic fetch_req_i,
  input wire logic [15:0] fetch_addr_i,
  output logic fetch_ready_o,
  output logic fetch_valid_o,
  output logic [7:0] fetch_data_o,
  input wire logic cpu_rd_req_i,
  input wire logic [23:0] cpu_addr_i,
  output logic cpu_ready_o,
  output logic cpu_valid_o,
  output logic [7:0] cpu_data_o,
  input wire logic pgm_req_i,
  input wire fg_pgm_cmd_t pgm_cmd_i,
  output logic pgm_ready_o,
  output logic pgm_done_o,
  output logic pgm_refused_o,
  output logic [7:0] pgm_rdata_o,
  output fg_flash_req_t fl_req_o,
  input wire logic [71:0] fl_rdata_i,
  input wire logic fl_busy_i,
  output fg_ee_req_t ee_req_o,
  input wire logic [7:0] ee_rdata_i,
  input wire logic ee_busy_i,
  input wire logic ecc_clr_i,
  output logic ecc_sbe_o,
  output logic ecc_dbe_o,
  output logic ecc_irq_o
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  fg_state_t state_reg, state_next;
  fg_src_t src_reg, src_next;
  logic tgt_ee_reg;
  logic [2:0] bsel_reg;
  logic [FG_ROW_W-1:0] row_reg;
  logic [63:0] buf_data_reg;
  logic [FG_ROW_W-1:0] buf_row_reg;
  logic buf_valid_reg;
  logic [71:0] fl_latch_reg;
  logic [127:0] ee_latch_reg;
  fg_prot_t prot_reg [FG_BLK_N];
  fg_flash_req_t fl_req_reg, fl_req_next;
  fg_ee_req_t ee_req_reg, ee_req_next;
  logic fetch_valid_reg;
  logic [7:0] fetch_data_reg;
  logic cpu_valid_reg;
  logic [7:0] cpu_data_reg;
  logic pgm_done_reg;
  logic pgm_refused_reg;
  logic [7:0] pgm_rdata_reg;
  logic ecc_sbe_reg;
  logic ecc_dbe_reg;

  // -------------------------------------------------------------------
  // request decode and arbitration
  // -------------------------------------------------------------------
  wire logic idle = (state_reg == FG_S_IDLE);
  wire fg_op_t op = pgm_cmd_i.op;
  wire logic [7:0] pgm_blk = pgm_cmd_i.addr[15:8];
  wire fg_prot_t pgm_lvl = prot_reg[pgm_blk];
  wire logic is_ee_op = (op == FG_OP_EE_LOAD) || (op == FG_OP_EE_WRITE);
  // busy rises one cycle after the strobe, so the strobe cycle also blocks
  wire logic ee_block = ee_busy_i || ee_req_reg.wr;
  wire logic cpu_is_ee = (cpu_addr_i[23:11] == FG_EE_BASE_HI);
  wire logic cpu_is_ecc = (cpu_addr_i[23:13] == FG_ECC_BASE_HI);

  // priority: command port, then data reads, then fetches
  wire logic pgm_take = idle && pgm_req_i && !(is_ee_op && ee_block);
  wire logic cpu_take = idle && !pgm_take && cpu_rd_req_i
                        && !(cpu_is_ee && ee_block);
  // fetch waits only on the flash engine, never on EEPROM busy
  wire logic fetch_take = idle && !pgm_take && !cpu_take
                          && fetch_req_i;
  // the 16-bit fetch address reaches main flash rows only
  wire logic fetch_hit = buf_valid_reg
                         && (buf_row_reg == fetch_addr_i[15:3]);

  // -------------------------------------------------------------------
  // protection gating
  // -------------------------------------------------------------------
  wire logic rd_ok = fg_allow(pgm_lvl, pgm_cmd_i.ext, 1'b0);
  wire logic wr_ok = fg_allow(pgm_lvl, pgm_cmd_i.ext, 1'b1);
  // a level is written once into an erased unit and then sticks
  wire logic set_ok = (pgm_lvl == FG_PROT_OPEN);
  wire logic pgm_refuse = ((op == FG_OP_FL_READ) && !rd_ok)
                          || ((op == FG_OP_FL_PROG) && !wr_ok)
                          || ((op == FG_OP_SET_PROT) && !set_ok);
  wire logic go_pgm_rd = pgm_take && (op == FG_OP_FL_READ) && rd_ok;
  wire logic go_pgm_wr = pgm_take && (op == FG_OP_FL_PROG) && wr_ok;
  wire logic go_erase = pgm_take && (op == FG_OP_ERASE_ALL);
  wire logic go_set = pgm_take && (op == FG_OP_SET_PROT) && set_ok;
  wire logic go_ee_wr = pgm_take && (op == FG_OP_EE_WRITE);
  wire logic go_fl_load = pgm_take && (op == FG_OP_FL_LOAD)
                          && (pgm_cmd_i.addr[3:0] <= FG_CHK_SLOT);
  wire logic go_ee_load = pgm_take && (op == FG_OP_EE_LOAD);
  wire logic go_cpu_fl = cpu_take && cpu_is_ecc;
  wire logic go_cpu_ee = cpu_take && cpu_is_ee;
  wire logic cpu_unmapped = cpu_take && !cpu_is_ee && !cpu_is_ecc;
  wire logic go_fetch = fetch_take && !fetch_hit;
  wire logic go_issue = go_pgm_rd || go_pgm_wr || go_erase || go_cpu_fl
                        || go_cpu_ee || go_fetch;
  wire logic pgm_imm = pgm_take && !go_pgm_rd && !go_pgm_wr && !go_erase;

  // -------------------------------------------------------------------
  // array strobes
  // -------------------------------------------------------------------
  wire logic [7:0] latch_chk_gen = fg_ecc_gen(fl_latch_reg[63:0]);
  // with correction off the check slot carries user config data
  wire logic [7:0] prog_chk = ecc_en_i ? latch_chk_gen
                                       : fl_latch_reg[71:64];
  // cpu check-area byte n is the check byte of row n
  wire logic [FG_ROW_W-1:0] issue_row =
    go_cpu_fl ? cpu_addr_i[12:0] :
    go_fetch ? fetch_addr_i[15:3] : pgm_cmd_i.addr[15:3];
  wire logic [2:0] issue_bsel = go_fetch ? fetch_addr_i[2:0]
                                         : pgm_cmd_i.addr[2:0];

  always_comb begin
    fl_req_next.rd = go_pgm_rd || go_cpu_fl || go_fetch;
    fl_req_next.wr = go_pgm_wr;
    fl_req_next.erase_all = go_erase;
    fl_req_next.row = issue_row;
    fl_req_next.wdata = {prog_chk, fl_latch_reg[63:0]};
    ee_req_next.rd = go_cpu_ee;
    ee_req_next.wr = go_ee_wr;
    ee_req_next.addr = go_ee_wr ? {pgm_cmd_i.addr[10:4], 4'h0}
                                : cpu_addr_i[10:0];
    ee_req_next.wdata = ee_latch_reg;
  end

  always_comb begin
    src_next = src_reg;
    if (go_cpu_fl || go_cpu_ee) begin
      src_next = FG_SRC_CPU;
    end else if (go_fetch) begin
      src_next = FG_SRC_FETCH;
    end else if (go_issue) begin
      src_next = FG_SRC_PGM;
    end
  end

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FG_S_IDLE: begin
        if (go_issue) begin
          state_next = FG_S_ISSUE;
        end
      end
      FG_S_ISSUE: begin
        if (fl_req_reg.rd || ee_req_reg.rd) begin
          state_next = FG_S_CAPT;
        end else begin
          state_next = FG_S_WAIT;
        end
      end
      FG_S_CAPT: state_next = FG_S_IDLE;
      FG_S_WAIT: begin
        if (!fl_busy_i) begin
          state_next = FG_S_IDLE;
        end
      end
      default: state_next = FG_S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= FG_S_IDLE;
      src_reg <= FG_SRC_FETCH;
      tgt_ee_reg <= 1'b0;
      bsel_reg <= 3'h0;
      row_reg <= 13'h0000;
      fl_req_reg <= '0;
      ee_req_reg <= '0;
    end else begin
      state_reg <= state_next;
      src_reg <= src_next;
      fl_req_reg <= fl_req_next;
      ee_req_reg <= ee_req_next;
      if (go_issue) begin
        tgt_ee_reg <= go_cpu_ee;
        bsel_reg <= issue_bsel;
        row_reg <= issue_row;
      end
    end
  end

  // -------------------------------------------------------------------
  // row capture and check
  // -------------------------------------------------------------------
  logic [63:0] cor_data;
  logic dec_sbe;
  logic dec_dbe;

  fg_secded u_secded (
    .data_i(fl_rdata_i[63:0]),
    .chk_i(fl_rdata_i[71:64]),
    .en_i(ecc_en_i),
    .data_o(cor_data),
    .sbe_o(dec_sbe),
    .dbe_o(dec_dbe)
  );

  wire logic capt = (state_reg == FG_S_CAPT);
  wire logic capt_fl = capt && !tgt_ee_reg;
  wire logic capt_fetch = capt_fl && (src_reg == FG_SRC_FETCH);
  wire logic capt_pgm = capt_fl && (src_reg == FG_SRC_PGM);
  // check-area data reads are raw bytes, not program memory
  wire logic capt_code = capt_fl && (src_reg != FG_SRC_CPU);
  wire logic wait_done = (state_reg == FG_S_WAIT) && !fl_busy_i;

  wire logic fetch_valid_next = (fetch_take && fetch_hit) || capt_fetch;
  wire logic [7:0] fetch_data_next =
    capt_fetch ? fg_byte(cor_data, bsel_reg)
               : fg_byte(buf_data_reg, fetch_addr_i[2:0]);
  wire logic cpu_valid_next = cpu_unmapped || (capt && src_reg == FG_SRC_CPU);
  // EEPROM bytes pass straight through with no checking
  wire logic [7:0] cpu_data_next =
    cpu_unmapped ? FG_REFUSED_DATA :
    tgt_ee_reg ? ee_rdata_i : fl_rdata_i[71:64];
  wire logic pgm_done_next = (pgm_take && pgm_imm) || capt_pgm || wait_done;
  wire logic [7:0] pgm_rdata_next =
    capt_pgm ? fg_byte(cor_data, bsel_reg) : FG_REFUSED_DATA;

  // -------------------------------------------------------------------
  // fetch buffer
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || go_pgm_wr || go_erase) begin
      buf_valid_reg <= 1'b0;
      buf_row_reg <= 13'h0000;
      buf_data_reg <= 64'h0;
    end else if (capt_fetch) begin
      buf_valid_reg <= 1'b1;
      buf_row_reg <= row_reg;
      buf_data_reg <= cor_data;
    end
  end

  // -------------------------------------------------------------------
  // protection table and write latches
  // -------------------------------------------------------------------
  // levels come up open here; a real part restores them from the array
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int b = 0; b < FG_BLK_N; b++) begin
        prot_reg[b] <= FG_PROT_RST;
      end
    end else if (go_erase) begin
      for (int b = 0; b < FG_BLK_N; b++) begin
        prot_reg[b] <= FG_PROT_OPEN;
      end
    end else if (go_set) begin
      prot_reg[pgm_blk] <= fg_prot_t'(pgm_cmd_i.data[1:0]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fl_latch_reg <= FG_FL_LATCH_RST;
      ee_latch_reg <= FG_EE_LATCH_RST;
    end else begin
      if (go_fl_load) begin
        fl_latch_reg[{pgm_cmd_i.addr[3:0], 3'b000} +: 8] <= pgm_cmd_i.data;
      end
      if (go_ee_load) begin
        ee_latch_reg[{pgm_cmd_i.addr[3:0], 3'b000} +: 8] <= pgm_cmd_i.data;
      end
    end
  end

  // -------------------------------------------------------------------
  // answers and error flags
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fetch_valid_reg <= 1'b0;
      fetch_data_reg <= 8'h00;
      cpu_valid_reg <= 1'b0;
      cpu_data_reg <= 8'h00;
      pgm_done_reg <= 1'b0;
      pgm_refused_reg <= 1'b0;
      pgm_rdata_reg <= 8'h00;
    end else begin
      fetch_valid_reg <= fetch_valid_next;
      cpu_valid_reg <= cpu_valid_next;
      pgm_done_reg <= pgm_done_next;
      pgm_refused_reg <= pgm_take && pgm_refuse;
      if (fetch_valid_next) begin
        fetch_data_reg <= fetch_data_next;
      end
      if (cpu_valid_next) begin
        cpu_data_reg <= cpu_data_next;
      end
      if (pgm_done_next) begin
        pgm_rdata_reg <= pgm_rdata_next;
      end
    end
  end

  // a new error in the clear cycle wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ecc_sbe_reg <= 1'b0;
      ecc_dbe_reg <= 1'b0;
    end else begin
      ecc_sbe_reg <= (capt_code && dec_sbe)
                     || (ecc_sbe_reg && !ecc_clr_i);
      ecc_dbe_reg <= (capt_code && dec_dbe)
                     || (ecc_dbe_reg && !ecc_clr_i);
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign fetch_ready_o = fetch_take;
  assign cpu_ready_o = cpu_take;
  assign pgm_ready_o = pgm_take;
  assign fetch_valid_o = fetch_valid_reg;
  assign fetch_data_o = fetch_data_reg;
  assign cpu_valid_o = cpu_valid_reg;
  assign cpu_data_o = cpu_data_reg;
  assign pgm_done_o = pgm_done_reg;
  assign pgm_refused_o = pgm_refused_reg;
  assign pgm_rdata_o = pgm_rdata_reg;
  assign fl_req_o = fl_req_reg;
  assign ee_req_o = ee_req_reg;
  assign ecc_sbe_o = ecc_sbe_reg;
  assign ecc_dbe_o = ecc_dbe_reg;
  assign ecc_irq_o = ecc_sbe_reg || ecc_dbe_reg;

endmodule

//--- bench/fg_mem_model.sv
/* Partner model of the flash and EEPROM array macros.
   Assumes one-cycle strobes and a free-running system clock. */
module fg_mem_model
  import fg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire fg_flash_req_t fl_req_i,
  output logic [71:0] fl_rdata_o = 72'h0,
  output logic fl_busy_o,
  input wire fg_ee_req_t ee_req_i,
  output logic [7:0] ee_rdata_o = 8'h00,
  output logic ee_busy_o
);
  logic [71:0] fl [int];
  logic [7:0] ee [int];
  int fcnt = 0;
  int ecnt = 0;
  bit slow = 1'b0;

  assign fl_busy_o = fcnt != 0;
  assign ee_busy_o = ecnt != 0;

  // read data holds one cycle only, then turns over
  always @(posedge sys_clk_i) begin
    fl_rdata_o <= ~fl_rdata_o;
    ee_rdata_o <= ~ee_rdata_o;
    fcnt <= (fcnt != 0) ? fcnt - 1 : 0;
    ecnt <= (ecnt != 0) ? ecnt - 1 : 0;
    if (fl_req_i.rd) begin
      fl_rdata_o <= fl.exists(fl_req_i.row) ? fl[fl_req_i.row] : '1;
    end
    if (fl_req_i.wr || fl_req_i.erase_all) begin
      // alternate quick and slow completions
      fcnt <= slow ? 7 : 2;
      slow <= !slow;
      if (fl_req_i.erase_all) begin
        fl.delete();
      end else begin
        fl[fl_req_i.row] = fl_req_i.wdata;
      end
    end
    if (ee_req_i.rd) begin
      ee_rdata_o <= ee.exists(ee_req_i.addr) ? ee[ee_req_i.addr] : 8'hFF;
    end
    if (ee_req_i.wr) begin
      ecnt <= slow ? 9 : 3;
      for (int i = 0; i < 16; i++) begin
        ee[{ee_req_i.addr[10:4], i[3:0]}] = ee_req_i.wdata[8*i +: 8];
      end
    end
  end
endmodule

//--- bench/fg_guard_chk.sv
/* Port-level checker for fg_guard.
   Assumes one clock and a synchronous active-high reset. */
module fg_guard_chk
  import fg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ecc_en_i,
  input wire logic fetch_req_i,
  input wire logic fetch_ready_o,
  input wire logic fetch_valid_o,
  input wire logic cpu_rd_req_i,
  input wire logic pgm_req_i,
  input wire logic pgm_done_o,
  input wire logic pgm_refused_o,
  input wire logic [7:0] pgm_rdata_o,
  input wire fg_flash_req_t fl_req_o,
  input wire logic fl_busy_i,
  input wire fg_ee_req_t ee_req_o,
  input wire logic ee_busy_i,
  input wire logic ecc_clr_i,
  input wire logic ecc_sbe_o,
  input wire logic ecc_dbe_o,
  input wire logic ecc_irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_fetch_take_answer: assert property (
    fetch_req_i && fetch_ready_o |-> ##[1:3] fetch_valid_o)
    else $error("fetch taken, no answer");
  a_row_read_once: assert property (
    fl_req_o.rd |=> !fl_req_o.rd)
    else $error("row read strobe too long");
  a_busy_stalls_fetch: assert property (
    fl_busy_i |-> !fetch_ready_o)
    else $error("fetch taken while flash busy");
  a_no_write_busy: assert property (
    fl_busy_i |-> !fl_req_o.wr && !fl_req_o.erase_all)
    else $error("flash write issued while busy");
  a_irq_from_flags: assert property (
    ecc_irq_o == (ecc_sbe_o || ecc_dbe_o))
    else $error("irq not OR of flags");
  a_sbe_sticky: assert property (
    ecc_sbe_o && !ecc_clr_i |=> ecc_sbe_o)
    else $error("single flag dropped");
  a_dbe_sticky: assert property (
    $past(ecc_dbe_o) && !$past(ecc_clr_i) |-> ecc_dbe_o)
    else $error("double flag dropped");
  a_flag_needs_ecc: assert property (
    $rose(ecc_sbe_o) || $rose(ecc_dbe_o) |-> ecc_en_i)
    else $error("flag raised, ecc off");
  a_refuse_no_effect: assert property (
    pgm_refused_o |-> pgm_done_o && !fl_req_o.wr &&
      pgm_rdata_o == FG_REFUSED_DATA)
    else $error("refused command had an effect");
  a_ee_no_write_busy: assert property (
    ee_busy_i |-> !ee_req_o.wr)
    else $error("eeprom write issued while busy");
  a_ee_keeps_fetch: assert property (
    ee_busy_i && fetch_req_i && !cpu_rd_req_i && !pgm_req_i &&
      !fl_busy_i |-> ##[0:4] fetch_ready_o)
    else $error("fetch stalled by eeprom write");
endmodule

bind fg_guard fg_guard_chk i_chk (.*);

//--- bench/fg_guard_tb_top.sv
/* Self-checking bench for fg_guard with a reference model.
   Assumes fg_mem_model plays the array macros. */
module fg_guard_tb_top
  import fg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ecc_en_i = 1'b0;
  logic ecc_clr_i = 1'b0;
  logic fetch_req_i = 1'b0;
  logic [15:0] fetch_addr_i = 16'h0000;
  logic cpu_rd_req_i = 1'b0;
  logic [23:0] cpu_addr_i = 24'h000000;
  logic pgm_req_i = 1'b0;
  fg_pgm_cmd_t pgm_cmd_i = '0;
  logic fetch_ready_o, fetch_valid_o, cpu_ready_o, cpu_valid_o;
  logic pgm_ready_o, pgm_done_o, pgm_refused_o, fl_busy_i, ee_busy_i;
  logic ecc_sbe_o, ecc_dbe_o, ecc_irq_o;
  logic [7:0] fetch_data_o, cpu_data_o, pgm_rdata_o, ee_rdata_i;
  logic [71:0] fl_rdata_i;
  fg_flash_req_t fl_req_o;
  fg_ee_req_t ee_req_o;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 10828;
  int prot [256];
  int brow = -1;
  logic [71:0] flat = '0;
  logic [127:0] elat = '0;
  logic [63:0] fmem [int];
  logic [7:0] emem [int];

  always #25 sys_clk_i = ~sys_clk_i;

  fg_guard i_dut (.*);
  fg_mem_model i_mem (.sys_clk_i(sys_clk_i), .fl_req_i(fl_req_o),
    .fl_rdata_o(fl_rdata_i), .fl_busy_o(fl_busy_i), .ee_req_i(ee_req_o),
    .ee_rdata_o(ee_rdata_i), .ee_busy_o(ee_busy_i));

  // -----
  // tasks
  // -----
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask

  function automatic logic [7:0] frd(input logic [15:0] a);
    if (!fmem.exists(a[15:3])) return 8'hFF;
    return fmem[a[15:3]][{a[2:0], 3'b000} +: 8];
  endfunction

  task automatic pgm(input fg_op_t op, input logic ext,
                     input logic [15:0] a, input logic [7:0] d);
    int lv, n;
    bit xr;
    lv = prot[a[15:8]];
    xr = (op == FG_OP_FL_READ && ext && lv != 0) ||
         (op == FG_OP_FL_PROG && (ext ? lv >= 2 : lv == 3)) ||
         (op == FG_OP_SET_PROT && lv != 0);
    pgm_cmd_i = '{op, ext, a, d};
    pgm_req_i = 1'b1;
    #1;
    n = 0;
    while (pgm_ready_o !== 1'b1 && n++ < 100) tick();
    tick();
    pgm_req_i = 1'b0;
    while (pgm_done_o !== 1'b1 && n++ < 100) tick();
    chk_bit("pgm_done_o", 1'b1, pgm_done_o);
    chk_bit("pgm_refused_o", xr, pgm_refused_o);
    chk_byte("pgm_rdata_o", (op == FG_OP_FL_READ && !xr) ? frd(a) : 8'h00,
             pgm_rdata_o);
    if (!xr) begin
      case (op)
        FG_OP_FL_LOAD: if (a[3:0] <= 4'h8) flat[{a[3:0], 3'b000} +: 8] = d;
        FG_OP_FL_PROG: begin
          fmem[a[15:3]] = flat[63:0];
          brow = -1;
        end
        FG_OP_ERASE_ALL: begin
          fmem.delete();
          prot = '{default: 0};
          brow = -1;
        end
        FG_OP_SET_PROT: prot[a[15:8]] = int'(d[1:0]);
        FG_OP_EE_LOAD: elat[{a[3:0], 3'b000} +: 8] = d;
        FG_OP_EE_WRITE: for (int i = 0; i < 16; i++) begin
          emem[{a[10:4], i[3:0]}] = elat[8*i +: 8];
        end
        default: ;
      endcase
    end
    tick();
  endtask

  task automatic fetch(input logic [15:0] a, input bit dchk);
    int n, lat;
    fetch_addr_i = a;
    fetch_req_i = 1'b1;
    #1;
    n = 0;
    while (fetch_ready_o !== 1'b1 && n++ < 100) tick();
    tick();
    fetch_req_i = 1'b0;
    lat = 1;
    while (fetch_valid_o !== 1'b1 && lat++ < 100) tick();
    chk_byte("fetch latency", 8'(brow == int'(a[15:3]) ? 1 : 3),
             8'(lat));
    if (dchk) chk_byte("fetch_data_o", frd(a), fetch_data_o);
    brow = int'(a[15:3]);
    tick();
  endtask

  task automatic cpu(input logic [23:0] a, input logic [7:0] exp,
                     input int xl);
    int n, lat;
    cpu_addr_i = a;
    cpu_rd_req_i = 1'b1;
    #1;
    n = 0;
    while (cpu_ready_o !== 1'b1 && n++ < 100) tick();
    tick();
    cpu_rd_req_i = 1'b0;
    lat = 1;
    while (cpu_valid_o !== 1'b1 && lat++ < 100) tick();
    chk_byte("cpu latency", 8'(xl), 8'(lat));
    chk_byte("cpu_data_o", exp, cpu_data_o);
    tick();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic clear_flags();
    ecc_clr_i = 1'b1;
    tick();
    ecc_clr_i = 1'b0;
    tick();
    chk_bit("ecc_irq_o", 1'b0, ecc_irq_o);
  endtask

  // -------------
  // main sequence
  // -------------
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    tick();
    for (int lv = 0; lv < 4; lv++) begin
      for (int ex = 0; ex < 2; ex++) begin
        pgm(FG_OP_ERASE_ALL, 1'b0, 16'h0000, 8'h00);
        pgm(FG_OP_FL_LOAD, 1'b0, 16'h0000, 8'($random(seed)));
        pgm(FG_OP_SET_PROT, 1'b0, 16'h0000, 8'(lv));
        pgm(FG_OP_SET_PROT, 1'b0, 16'h0000, 8'h00);
        pgm(FG_OP_FL_PROG, ex[0], 16'h0000, 8'h00);
        pgm(FG_OP_FL_READ, ex[0], 16'h0000, 8'h00);
        pgm(FG_OP_FL_READ, 1'b0, 16'h0000, 8'h00);
      end
    end
    $display("protection test done");
    ecc_en_i = 1'b1;
    pgm(FG_OP_ERASE_ALL, 1'b0, 16'h0000, 8'h00);
    for (int r = 1; r < 3; r++) begin
      for (int i = 0; i < 8; i++) begin
        pgm(FG_OP_FL_LOAD, 1'b0, 16'(i), 8'($random(seed)));
      end
      fork
        pgm(FG_OP_FL_PROG, 1'b0, 16'(8 * r), 8'h00);
        begin
          tick();
          if (r == 2) fetch(16'h000F, 1'b1);
        end
      join
    end
    for (int i = 0; i < 8; i++) fetch(16'(8 + i), 1'b1);
    i_mem.fl[1][5] = ~i_mem.fl[1][5];
    fetch(16'h0010, 1'b1);
    fetch(16'h0008, 1'b1);
    repeat (4) tick();
    chk_bit("ecc_sbe_o", 1'b1, ecc_sbe_o);
    clear_flags();
    i_mem.fl[1][20] = ~i_mem.fl[1][20];
    fetch(16'h0010, 1'b1);
    fetch(16'h0008, 1'b0);
    tick();
    chk_bit("ecc_dbe_o", 1'b1, ecc_dbe_o);
    clear_flags();
    ecc_en_i = 1'b0;
    fmem[1] = fmem[1] ^ 64'h0000000000100020;
    fetch(16'h0010, 1'b1);
    fetch(16'h0008, 1'b1);
    fetch(16'h000A, 1'b1);
    chk_bit("ecc_irq_o", 1'b0, ecc_irq_o);
    $display("ecc test done");
    pgm(FG_OP_FL_LOAD, 1'b0, 16'h0008, 8'($random(seed)));
    pgm(FG_OP_FL_LOAD, 1'b0, 16'h0009, 8'h3C);
    pgm(FG_OP_FL_PROG, 1'b0, 16'h0018, 8'h00);
    cpu(24'h080003, flat[71:64], 3);
    cpu(24'h004000, 8'h00, 1);
    $display("check area test done");
    for (int i = 0; i < 16; i++) begin
      pgm(FG_OP_EE_LOAD, 1'b0, 16'(i), 8'($random(seed)));
    end
    pgm(FG_OP_EE_WRITE, 1'b0, 16'h07F0, 8'h00);
    fetch(16'h0018, 1'b1);
    for (int i = 0; i < 16; i += 5) begin
      cpu(24'h0087F0 + 24'(i), emem[32'h7F0 + i], 3);
    end
    $display("eeprom test done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    give_verdict();
  end
endmodule
